// [design/dmpp_pkg.sv]
// shared constants and types for the dma programming port
package dmpp_pkg;
   // register port offsets
   localparam logic [7:0] OFS_PORT = 8'h00;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
   // command group codes
   localparam logic [7:0] CMD_LOAD = 8'hCF;
   localparam logic [7:0] CMD_CONTINUE = 8'hD3;
   localparam logic [7:0] CMD_ENABLE = 8'h87;
   localparam logic [7:0] CMD_DISABLE = 8'h83;
   localparam logic [7:0] CMD_RD_STATUS = 8'hBF;
   localparam logic [7:0] CMD_RB_START = 8'hA7;
   localparam logic [7:0] CMD_RB_MASK = 8'hBB;
   localparam logic [7:0] CMD_REINIT = 8'h8B;
   localparam logic [7:0] CMD_RESET = 8'hC3;
   localparam logic [7:0] BASE_A_XFER = 8'h05;
   localparam logic [1:0] XFER_ONLY = 2'b01;
   // base byte flag positions
   localparam int B_ASRC = 2;
   localparam int B_ALO = 3;
   localparam int B_AHI = 4;
   localparam int B_LLO = 5;
   localparam int B_LHI = 6;
   localparam int B_IO = 3;
   localparam int B_CHG = 4;
   localparam int B_TIM = 6;
   localparam int B_MSK = 3;
   localparam int B_MAT = 4;
   localparam int B_EN = 6;
   localparam int B_BLO = 2;
   localparam int B_BHI = 3;
   localparam int B_INT = 4;
   localparam int B_AUTO = 5;
   // follow-on byte slots, served lowest first
   localparam int NSLOT = 12;
   localparam logic [3:0] SL_ALO = 4'h0;
   localparam logic [3:0] SL_AHI = 4'h1;
   localparam logic [3:0] SL_LLO = 4'h2;
   localparam logic [3:0] SL_LHI = 4'h3;
   localparam logic [3:0] SL_ATIM = 4'h4;
   localparam logic [3:0] SL_BTIM = 4'h5;
   localparam logic [3:0] SL_MASK = 4'h6;
   localparam logic [3:0] SL_MATCH = 4'h7;
   localparam logic [3:0] SL_BLO = 4'h8;
   localparam logic [3:0] SL_BHI = 4'h9;
   localparam logic [3:0] SL_INT = 4'hA;
   localparam logic [3:0] SL_RDM = 4'hB;
   // status byte and readback
   localparam logic [7:0] ST_BASE = 8'h1A;
   localparam int ST_MOVED = 0;
   localparam int ST_EOB_N = 5;
   localparam int RB_N = 7;
   localparam logic [6:0] RST_RDMASK = 7'h7F;
   // interrupt status bits
   localparam int IRQ_W = 2;
   localparam int IRQ_EOB = 0;
   localparam int IRQ_GRANT = 1;
   // address change and cycle timing codes
   localparam logic [1:0] CHG_DEC = 2'b00;
   localparam logic [1:0] CHG_INC = 2'b01;
   localparam logic [1:0] TIM_STD = 2'b00;
   localparam logic [1:0] TIM_SHORT = 2'b01;
   localparam logic [2:0] CYC_STD = 3'h3;
   localparam logic [2:0] CYC_SHORT = 3'h2;
   localparam logic [2:0] CYC_LONG = 3'h4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ = 2'b01,
      ST_READ = 2'b11,
      ST_WRITE = 2'b10
   } dmpp_state_e;

   typedef struct packed {
      logic isIo;
      logic [1:0] chg;
      logic [1:0] timing;
   } dmpp_cfg_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic mreqN;
      logic iorqN;
      logic rdN;
      logic wrN;
      logic ctrlOe;
      logic dataOe;
   } dmpp_pins_s;

   typedef struct packed {
      dmpp_state_e state;
      logic [11:0] pend;
      logic [15:0] aStart;
      logic [15:0] bStart;
      logic [15:0] aCnt;
      logic [15:0] bCnt;
      logic [15:0] blockLen;
      logic [15:0] byteCnt;
      logic aSrc;
      logic [1:0] xferMode;
      dmpp_cfg_s aCfg;
      dmpp_cfg_s bCfg;
      logic [7:0] hold;
      logic autoRst;
      logic enabled;
      logic stNext;
      logic eob;
      logic moved;
      logic cycStart;
      logic [6:0] rdMask;
      logic [6:0] rbPend;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic irq;
      logic busReqOe;
      logic [7:0] rdata;
   } dmpp_core_s;

   localparam dmpp_core_s CORE_RST = '{state: ST_IDLE, rdMask: RST_RDMASK, default: '0};
endpackage : dmpp_pkg

// [design/dmpp_bus_cycle.sv]
// one memory or i/o read or write cycle as bus master
`timescale 1ns/10ps
`default_nettype none
module dmpp_bus_cycle (
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic isIo,
   input wire logic isWrite,
   input wire logic [1:0] timing,
   input wire logic master,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] dataIn,
   output var dmpp_pkg::dmpp_pins_s pins,
   output logic [7:0] rdData,
   output logic done
);
   import dmpp_pkg::*;
   logic [2:0] t_q, t_d, last_q, last_d;
   logic active_q, active_d, done_d;
   logic [7:0] rd_d;
   dmpp_pins_s pins_d;

   always_comb begin
      t_d = t_q;
      last_d = last_q;
      active_d = active_q;
      done_d = 1'b0;
      rd_d = rdData;
      pins_d = pins;
      if (start) begin
         active_d = 1'b1;
         t_d = 3'h0;
         // program chooses short, standard or long cycle
         unique case (timing)
            TIM_STD: last_d = CYC_STD - 3'h1;
            TIM_SHORT: last_d = CYC_SHORT - 3'h1;
            default: last_d = CYC_LONG - 3'h1;
         endcase
         pins_d.addr = addr;
         pins_d.data = wdata;
      end else if (active_q) begin
         t_d = t_q + 3'h1;
         // request and strobe fall together after address setup
         if (t_q == 3'h0) begin
            pins_d.mreqN = isIo;
            pins_d.iorqN = !isIo;
            pins_d.rdN = isWrite;
            pins_d.wrN = !isWrite;
         end
         if (t_q == last_q) begin
            pins_d.mreqN = 1'b1;
            pins_d.iorqN = 1'b1;
            pins_d.rdN = 1'b1;
            pins_d.wrN = 1'b1;
            active_d = 1'b0;
            done_d = 1'b1;
            rd_d = dataIn;
         end
      end
      pins_d.dataOe = active_d && isWrite;
      pins_d.ctrlOe = master;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         t_q <= 3'h0;
         last_q <= 3'h0;
         active_q <= 1'b0;
         done <= 1'b0;
         rdData <= 8'h00;
         pins <= '{mreqN: 1'b1, iorqN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
      end else begin
         t_q <= t_d;
         last_q <= last_d;
         active_q <= active_d;
         done <= done_d;
         rdData <= rd_d;
         pins <= pins_d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_cycStd;
      (start && timing == TIM_STD) |-> ##4 done;
   endproperty
   a_cycStd: assert property (p_cycStd) else $error("standard cycle length wrong");
   property p_cycShort;
      (start && timing == TIM_SHORT) |-> ##3 done;
   endproperty
   a_cycShort: assert property (p_cycShort) else $error("short cycle length wrong");
   property p_memRead;
      (start && !isWrite && !isIo) |-> ##2 (!pins.rdN && !pins.mreqN && pins.iorqN);
   endproperty
   a_memRead: assert property (p_memRead) else $error("memory read strobes wrong");
endmodule : dmpp_bus_cycle
`default_nettype wire

// [design/dmpp_program_port.sv]
// command interpreter, readback and transfer engine of the dma programming port
`timescale 1ns/10ps
`default_nettype none
// Contract
// - status read needs a fresh status command
// - readback returns masked registers in order
// - block moves length plus one bytes
// - parameter bytes follow their base byte
// - base byte 05 selects A-source transfer
// - enable command starts the device
// - bus cycles match host processor cycles
// - cycle timing programmable short or long
// - interrupt and bus request are open drain
// - no transfer before enable is written
module dmpp_program_port (
   input wire logic clock,
   input wire logic reset,
   input wire logic selectN,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   output logic irq,
   output logic intOut,
   output logic intOe,
   input wire logic busReqIn,
   output logic busReqOut,
   output logic busReqOe,
   input wire logic busAckN,
   input wire logic [7:0] dataIn,
   output var dmpp_pkg::dmpp_pins_s pins
);
   import dmpp_pkg::*;
   dmpp_core_s core_q, core_d;
   dmpp_cfg_s cfg;
   logic wrPort, rdPort, selWr, selRd, cycDone, srcA, fin;
   logic [3:0] slot, rbIdx;
   logic [7:0] b, cycRdata, statusByte, rbNow;
   logic [15:0] cycAddr;

   function automatic logic [3:0] lowest(input logic [11:0] v);
      lowest = 4'h0;
      for (int i = NSLOT - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = 4'(i);
         end
      end
   endfunction : lowest

   function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] chg);
      unique case (chg)
         CHG_DEC: step = a - 16'h0001;
         CHG_INC: step = a + 16'h0001;
         default: step = a;
      endcase
   endfunction : step

   // nothing reaches the block unless selected
   assign selWr = regWr && !selectN;
   assign selRd = regRd && !selectN;
   assign wrPort = selWr && regAddr == OFS_PORT;
   assign rdPort = selRd && regAddr == OFS_PORT;
   assign b = regWdata;
   assign slot = lowest(core_q.pend);
   assign rbIdx = lowest({5'h00, core_q.rbPend});
   // in a read the source port is addressed, in a write the other one
   assign srcA = (core_q.state == ST_READ) == core_q.aSrc;
   assign cfg = srcA ? core_q.aCfg : core_q.bCfg;
   assign cycAddr = srcA ? core_q.aCnt : core_q.bCnt;
   assign statusByte = ST_BASE | (8'(core_q.moved) << ST_MOVED)
                     | (8'(!core_q.eob) << ST_EOB_N);

   always_comb begin
      unique case (rbIdx)
         4'h0: rbNow = statusByte;
         4'h1: rbNow = core_q.byteCnt[7:0];
         4'h2: rbNow = core_q.byteCnt[15:8];
         4'h3: rbNow = core_q.aCnt[7:0];
         4'h4: rbNow = core_q.aCnt[15:8];
         4'h5: rbNow = core_q.bCnt[7:0];
         4'h6: rbNow = core_q.bCnt[15:8];
         default: rbNow = 8'h00;
      endcase
   end

   // master cycles come from the shared cycle generator
   dmpp_bus_cycle dmpp_bus_cycle_inst (
      .clock(clock),
      .reset(reset),
      .start(core_q.cycStart),
      .isIo(cfg.isIo),
      .isWrite(core_q.state == ST_WRITE),
      .timing(cfg.timing),
      .master(core_q.state[1]),
      .addr(cycAddr),
      .wdata(core_q.hold),
      .dataIn(dataIn),
      .pins(pins),
      .rdData(cycRdata),
      .done(cycDone)
   );

   always_comb begin
      core_d = core_q;
      core_d.cycStart = 1'b0;
      core_d.rdata = 8'h00;
      fin = 1'b0;
      // clears go first so an event in the same cycle wins
      if (selWr && regAddr == OFS_IRQ_STAT) begin
         core_d.irqStat = core_q.irqStat & ~regWdata[IRQ_W-1:0];
      end
      if (selWr && regAddr == OFS_IRQ_MASK) begin
         core_d.irqMask = regWdata[IRQ_W-1:0];
      end
      unique case (core_q.state)
         ST_IDLE: begin
            // only an enabled device asks for the bus
            if (core_q.enabled && busReqIn) begin
               core_d.state = ST_REQ;
               core_d.busReqOe = 1'b1;
            end
         end
         ST_REQ: begin
            if (!core_q.enabled) begin
               core_d.state = ST_IDLE;
               core_d.busReqOe = 1'b0;
            end else if (!busAckN) begin
               core_d.state = ST_READ;
               core_d.cycStart = 1'b1;
               core_d.irqStat[IRQ_GRANT] = 1'b1;
            end
         end
         ST_READ: begin
            if (cycDone) begin
               core_d.hold = cycRdata;
               // search-only mode reads and never writes
               if (core_q.xferMode[0]) begin
                  core_d.state = ST_WRITE;
                  core_d.cycStart = 1'b1;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         ST_WRITE: begin
            fin = cycDone;
         end
      endcase
      if (fin) begin
         core_d.moved = 1'b1;
         core_d.byteCnt = core_q.byteCnt + 16'h0001;
         core_d.aCnt = step(core_q.aCnt, core_q.aCfg.chg);
         core_d.bCnt = step(core_q.bCnt, core_q.bCfg.chg);
         core_d.state = ST_READ;
         core_d.cycStart = 1'b1;
         // the count starts at zero, so length plus one bytes move
         if (core_q.byteCnt == core_q.blockLen) begin
            core_d.eob = 1'b1;
            core_d.irqStat[IRQ_EOB] = 1'b1;
            if (core_q.autoRst) begin
               core_d.aCnt = core_q.aStart;
               core_d.bCnt = core_q.bStart;
               core_d.byteCnt = 16'h0000;
            end else begin
               core_d.enabled = 1'b0;
            end
         end
         // a disable takes effect between bytes, never inside one
         if (!core_d.enabled) begin
            core_d.state = ST_IDLE;
            core_d.cycStart = 1'b0;
            core_d.busReqOe = 1'b0;
         end
      end
      // follow-on bytes fill the slots their base byte opened
      if (wrPort && core_q.pend != 12'h000) begin
         core_d.pend[slot] = 1'b0;
         unique case (slot)
            SL_ALO: core_d.aStart[7:0] = b;
            SL_AHI: core_d.aStart[15:8] = b;
            SL_LLO: core_d.blockLen[7:0] = b;
            SL_LHI: core_d.blockLen[15:8] = b;
            SL_ATIM: core_d.aCfg.timing = b[1:0];
            SL_BTIM: core_d.bCfg.timing = b[1:0];
            SL_BLO: core_d.bStart[7:0] = b;
            SL_BHI: core_d.bStart[15:8] = b;
            SL_RDM: core_d.rdMask = b[RB_N-1:0];
            // search and interrupt control bytes are swallowed here
            default: ;
         endcase
      end else if (wrPort) begin
         if (!b[7] && b[1:0] != 2'b00) begin
            core_d.aSrc = b[B_ASRC];
            core_d.xferMode = b[1:0];
            core_d.pend[SL_ALO] = b[B_ALO];
            core_d.pend[SL_AHI] = b[B_AHI];
            core_d.pend[SL_LLO] = b[B_LLO];
            core_d.pend[SL_LHI] = b[B_LHI];
         end else if (!b[7] && b[2]) begin
            core_d.aCfg.isIo = b[B_IO];
            core_d.aCfg.chg = b[B_CHG+:2];
            core_d.pend[SL_ATIM] = b[B_TIM];
         end else if (!b[7]) begin
            core_d.bCfg.isIo = b[B_IO];
            core_d.bCfg.chg = b[B_CHG+:2];
            core_d.pend[SL_BTIM] = b[B_TIM];
         end else if (b[1:0] == 2'b00) begin
            core_d.pend[SL_MASK] = b[B_MSK];
            core_d.pend[SL_MATCH] = b[B_MAT];
            // this bit is the same as the enable command
            if (b[B_EN]) begin
               core_d.enabled = 1'b1;
            end
         end else if (b[1:0] == 2'b01) begin
            core_d.pend[SL_BLO] = b[B_BLO];
            core_d.pend[SL_BHI] = b[B_BHI];
            core_d.pend[SL_INT] = b[B_INT];
         end else if (b[2:0] == 3'b010) begin
            core_d.autoRst = b[B_AUTO];
         end else begin
            unique case (b)
               // only the declared source is loaded
               CMD_LOAD: begin
                  if (core_q.aSrc) begin
                     core_d.aCnt = core_q.aStart;
                  end else begin
                     core_d.bCnt = core_q.bStart;
                  end
                  core_d.byteCnt = 16'h0000;
               end
               CMD_CONTINUE: core_d.byteCnt = 16'h0000;
               // start once the bus is won
               CMD_ENABLE: core_d.enabled = 1'b1;
               CMD_DISABLE: core_d.enabled = 1'b0;
               CMD_RD_STATUS: core_d.stNext = 1'b1;
               CMD_RB_START: begin
                  core_d.rbPend = core_q.rdMask;
                  core_d.stNext = 1'b0;
               end
               CMD_RB_MASK: core_d.pend[SL_RDM] = 1'b1;
               // a block end in the same cycle still sets the flags
               CMD_REINIT: begin
                  core_d.eob = fin && core_q.byteCnt == core_q.blockLen;
                  core_d.moved = fin;
               end
               CMD_RESET: begin
                  core_d.enabled = 1'b0;
                  core_d.autoRst = 1'b0;
                  core_d.pend = 12'h000;
                  core_d.aCfg.timing = TIM_STD;
                  core_d.bCfg.timing = TIM_STD;
               end
               default: ;
            endcase
         end
      end
      if (rdPort) begin
         if (core_q.stNext) begin
            core_d.rdata = statusByte;
            core_d.stNext = 1'b0;
         end else if (core_q.rbPend != 7'h00) begin
            core_d.rdata = rbNow;
            core_d.rbPend[rbIdx[2:0]] = 1'b0;
         end else begin
            core_d.rdata = 8'h00;
         end
      end else if (selRd && regAddr == OFS_IRQ_STAT) begin
         core_d.rdata = {6'h00, core_q.irqStat};
      end else if (selRd && regAddr == OFS_IRQ_MASK) begin
         core_d.rdata = {6'h00, core_q.irqMask};
      end
      core_d.irq = |(core_d.irqStat & core_d.irqMask);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         core_q <= CORE_RST;
      end else begin
         core_q <= core_d;
      end
   end

   assign regRdata = core_q.rdata;
   assign irq = core_q.irq;
   // open drain lines only ever pull low
   assign intOut = 1'b0;
   assign intOe = core_q.irq;
   assign busReqOut = 1'b0;
   assign busReqOe = core_q.busReqOe;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_statusCmd;
      wrPort && core_q.pend == 12'h000 && b == CMD_RD_STATUS;
   endsequence
   sequence s_enableCmd;
      wrPort && core_q.pend == 12'h000 && b == CMD_ENABLE;
   endsequence
   property p_statusArm;
      s_statusCmd |=> core_q.stNext;
   endproperty
   a_statusArm: assert property (p_statusArm) else $error("status not armed");
   property p_statusRead;
      (rdPort && core_q.stNext) |=> (regRdata == $past(statusByte) && !core_q.stNext);
   endproperty
   a_statusRead: assert property (p_statusRead) else $error("status read wrong");
   property p_rbStart;
      (wrPort && core_q.pend == 12'h000 && b == CMD_RB_START)
         |=> (core_q.rbPend == $past(core_q.rdMask) && !core_q.stNext);
   endproperty
   a_rbStart: assert property (p_rbStart) else $error("readback not started");
   property p_rbOrder;
      (rdPort && !core_q.stNext && core_q.rbPend != 7'h00) |=> regRdata == $past(rbNow);
   endproperty
   a_rbOrder: assert property (p_rbOrder) else $error("readback order wrong");
   property p_rbIdle;
      (rdPort && !core_q.stNext && core_q.rbPend == 7'h00) |=> regRdata == 8'h00;
   endproperty
   a_rbIdle: assert property (p_rbIdle) else $error("idle readback not zero");
   property p_blockEnd;
      (fin && core_q.byteCnt == core_q.blockLen && !core_q.autoRst && !wrPort)
         |=> (!core_q.enabled && core_q.eob && core_q.state == ST_IDLE);
   endproperty
   a_blockEnd: assert property (p_blockEnd) else $error("block end missed");
   property p_noStart;
      (!core_q.enabled && core_q.state == ST_IDLE) |=> core_q.state == ST_IDLE;
   endproperty
   a_noStart: assert property (p_noStart) else $error("started while disabled");
   property p_enable;
      s_enableCmd |=> core_q.enabled ##1 (core_q.state != ST_IDLE || !$past(busReqIn));
   endproperty
   a_enable: assert property (p_enable) else $error("enable did not start");
   property p_load;
      (wrPort && core_q.pend == 12'h000 && b == CMD_LOAD && core_q.aSrc)
         |=> (core_q.aCnt == $past(core_q.aStart) && core_q.byteCnt == 16'h0000);
   endproperty
   a_load: assert property (p_load) else $error("load wrong");
   property p_base;
      (wrPort && core_q.pend == 12'h000 && b == BASE_A_XFER)
         |=> (core_q.aSrc && core_q.xferMode == XFER_ONLY && core_q.pend == 12'h000);
   endproperty
   a_base: assert property (p_base) else $error("base byte decode wrong");
   property p_slot;
      (wrPort && core_q.pend != 12'h000 && slot == SL_ALO) |=> core_q.aStart[7:0] == $past(b);
   endproperty
   a_slot: assert property (p_slot) else $error("follow-on byte misplaced");
   property p_select;
      (regWr && selectN) |=> ($stable(core_q.pend) && $stable(core_q.rdMask));
   endproperty
   a_select: assert property (p_select) else $error("unselected write acted");
endmodule : dmpp_program_port
`default_nettype wire

// [bench/dmpp_far_model.sv]
// far side model: bus arbiter, memory and i/o target for master cycles
`timescale 1ns/10ps
`default_nettype none
module dmpp_far_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic busReqOe,
   input var dmpp_pkg::dmpp_pins_s pins,
   output logic busReqIn,
   output logic busAckN,
   output logic [7:0] dataIn,
   output logic [7:0] ioCount,
   output logic [15:0] lastRdAddr,
   output logic [15:0] lastWrAddr,
   output logic [7:0] lastWrData
);
   import dmpp_pkg::*;
   logic wrPrev;
   logic rdPrev;
   logic [7:0] noise;
   // wired request line, pull-up when nobody sinks it
   assign busReqIn = !busReqOe;
   // memory drives data only inside a memory read strobe
   assign dataIn = (!pins.rdN && !pins.mreqN) ? (pins.addr[7:0] ^ 8'hA5) : noise;
   always_ff @(posedge clock) begin
      noise <= noise + 8'h3D;
      wrPrev <= pins.wrN;
      rdPrev <= pins.rdN;
      busAckN <= !busReqOe;
      if (reset) begin
         ioCount <= 8'h00;
         noise <= 8'h5A;
      end else if (wrPrev && !pins.wrN && !pins.iorqN) begin
         ioCount <= ioCount + 8'h01;
         lastWrAddr <= pins.addr;
         lastWrData <= pins.data;
      end
      if (rdPrev && !pins.rdN && !pins.mreqN) begin
         lastRdAddr <= pins.addr;
      end
   end
endmodule : dmpp_far_model
`default_nettype wire

// [bench/dmpp_program_port_tb.sv]
// self-checking bench for the dma programming port
`timescale 1ns/10ps
`default_nettype none
module dmpp_program_port_tb;
   import dmpp_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic selectN = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic irq, intOut, intOe, busReqIn, busReqOut, busReqOe, busAckN;
   logic [7:0] dataIn, ioCount, lastWrData;
   logic [15:0] lastRdAddr, lastWrAddr, rd;
   dmpp_pins_s pins;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   dmpp_program_port dmpp_program_port_inst (.clock(clock), .reset(reset), .selectN(selectN),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irq(irq), .intOut(intOut), .intOe(intOe), .busReqIn(busReqIn),
      .busReqOut(busReqOut), .busReqOe(busReqOe), .busAckN(busAckN), .dataIn(dataIn),
      .pins(pins));
   dmpp_far_model dmpp_far_model_inst (.clock(clock), .reset(reset), .busReqOe(busReqOe),
      .pins(pins), .busReqIn(busReqIn), .busAckN(busAckN), .dataIn(dataIn),
      .ioCount(ioCount), .lastRdAddr(lastRdAddr), .lastWrAddr(lastWrAddr),
      .lastWrData(lastWrData));
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // select only while this device is addressed
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel = 1'b1);
      @(posedge clock);
      selectN <= !sel;
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      selectN <= 1'b1;
   endtask : wr
   task automatic rdreg(input logic [7:0] a);
      @(posedge clock);
      selectN <= 1'b0;
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      selectN <= 1'b1;
      #1 rd = {8'h00, regRdata};
   endtask : rdreg
   task automatic t_status;
      rdreg(OFS_IRQ_MASK);
      chk("mask reset", 16'h00, rd);
      wr(OFS_PORT, CMD_RD_STATUS);
      rdreg(OFS_PORT);
      chk("status", 16'h3A, rd);
      rdreg(OFS_PORT);
      chk("status again", 16'h00, rd);
      wr(OFS_PORT, CMD_RD_STATUS, 1'b0);
      rdreg(OFS_PORT);
      chk("deselected write", 16'h00, rd);
      rdreg(8'h0C);
      chk("unmapped", 16'h00, rd);
      $display("test status done");
   endtask : t_status
   task automatic t_program;
      logic [7:0] prog [16] = '{8'h79, 8'h50, 8'h10, 8'h02, 8'h00, 8'h14, 8'h28, 8'hC5,
         8'h05, 8'h8A, CMD_LOAD, BASE_A_XFER, CMD_LOAD, CMD_RB_MASK, 8'h7F, CMD_RB_START};
      logic [7:0] exp [8] = '{8'h3A, 8'h00, 8'h00, 8'h50, 8'h10, 8'h05, 8'h00, 8'h00};
      // fixed destination loaded while declared source
      foreach (prog[i]) wr(OFS_PORT, prog[i]);
      // every masked register is read out
      foreach (exp[i]) begin
         rdreg(OFS_PORT);
         chk("readback", {8'h00, exp[i]}, rd);
      end
      rdreg(OFS_PORT);
      chk("readback idle", 16'h00, rd);
      wr(OFS_PORT, CMD_RB_MASK);
      wr(OFS_PORT, 8'h0A);
      wr(OFS_PORT, CMD_RB_START);
      rdreg(OFS_PORT);
      chk("subset count lo", 16'h00, rd);
      rdreg(OFS_PORT);
      chk("subset A lo", 16'h50, rd);
      rdreg(OFS_PORT);
      chk("subset idle", 16'h00, rd);
      repeat (20) @(posedge clock);
      chk("no request before enable", 16'h0, {15'h0, busReqOe});
      $display("test program done");
   endtask : t_program
   task automatic t_transfer;
      wr(OFS_PORT, CMD_ENABLE);
      rd = 16'h0000;
      for (int i = 0; i < 100 && rd[IRQ_EOB] !== 1'b1; i++) rdreg(OFS_IRQ_STAT);
      chk("irq status", 16'h03, rd);
      chk("masked irq", 16'h0, {15'h0, irq});
      chk("io writes", 16'h03, {8'h00, ioCount});
      chk("fixed dest", 16'h0005, lastWrAddr);
      chk("last src", 16'h1052, lastRdAddr);
      chk("last data", 16'hF7, {8'h00, lastWrData});
      chk("bus released", 16'h0, {15'h0, busReqOe});
      chk("master oe off", 16'h0, {14'h0, pins.ctrlOe, pins.dataOe});
      wr(OFS_IRQ_MASK, 8'h01);
      @(posedge clock);
      #1 chk("irq raised", 16'h1, {15'h0, irq});
      chk("int pin", 16'h1, {15'h0, intOe});
      chk("open drain low", 16'h0, {14'h0, intOut, busReqOut});
      wr(OFS_IRQ_STAT, 8'h03);
      @(posedge clock);
      #1 chk("irq cleared", 16'h0, {15'h0, irq});
      wr(OFS_PORT, CMD_RD_STATUS);
      rdreg(OFS_PORT);
      chk("status after block", 16'h1B, rd);
      $display("test transfer done");
   endtask : t_transfer
   task automatic t_timing;
      // short source reads, long destination writes
      wr(OFS_PORT, 8'h54);
      wr(OFS_PORT, 8'h01);
      wr(OFS_PORT, 8'h68);
      wr(OFS_PORT, 8'h02);
      wr(OFS_PORT, CMD_LOAD);
      wr(OFS_PORT, CMD_REINIT);
      wr(OFS_PORT, CMD_RD_STATUS);
      rdreg(OFS_PORT);
      chk("status reinit", 16'h3A, rd);
      wr(OFS_PORT, CMD_ENABLE);
      rd = 16'h0000;
      for (int i = 0; i < 100 && rd[IRQ_EOB] !== 1'b1; i++) rdreg(OFS_IRQ_STAT);
      chk("timed io writes", 16'h06, {8'h00, ioCount});
      chk("timed last src", 16'h1052, lastRdAddr);
      chk("timed irq", 16'h1, {15'h0, irq});
      $display("test timing done");
   endtask : t_timing
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("ERROR timeout expected done seen hang");
         results();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_status();
      t_program();
      t_transfer();
      t_timing();
      results();
   end
endmodule : dmpp_program_port_tb
`default_nettype wire
